// file: shared/dma_map_pkg.sv
// Constants shared by the peripheral-request DMA channel.
// Assumes one clock domain; peripheral addresses are 16-bit byte addresses.
package dma_map_pkg;
  // Request-source codes (7 bits)
  localparam logic [6:0] SRC_EXT_INT_ZERO   = 7'h00;
  localparam logic [6:0] SRC_CAPTURE_1      = 7'h01;
  localparam logic [6:0] SRC_COMPARE_1      = 7'h02;
  localparam logic [6:0] SRC_CAPTURE_2      = 7'h05;
  localparam logic [6:0] SRC_COMPARE_2      = 7'h06;
  localparam logic [6:0] SRC_TIMER_2        = 7'h07;
  localparam logic [6:0] SRC_TIMER_3        = 7'h08;
  localparam logic [6:0] SRC_SERIAL_A       = 7'h0a;
  localparam logic [6:0] SRC_UART_A_RX      = 7'h0b;
  localparam logic [6:0] SRC_UART_A_TX      = 7'h0c;
  localparam logic [6:0] SRC_CONVERTER      = 7'h0d;
  localparam logic [6:0] SRC_UART_B_RX      = 7'h1e;
  localparam logic [6:0] SRC_UART_B_TX      = 7'h1f;
  localparam logic [6:0] SRC_SERIAL_B       = 7'h21;
  localparam logic [6:0] SRC_CAN_RX         = 7'h22;
  localparam logic [6:0] SRC_PARALLEL_PORT  = 7'h2d;
  localparam logic [6:0] SRC_CODEC          = 7'h3c;
  localparam logic [6:0] SRC_CAN_TX         = 7'h46;
  localparam logic [6:0] SRC_DAC_RIGHT      = 7'h4e;
  localparam logic [6:0] SRC_DAC_LEFT       = 7'h4f;

  // Peripheral register addresses
  localparam logic [15:0] capture_unit1_buffer          = 16'h0140;
  localparam logic [15:0] capture_unit2_buffer          = 16'h0144;
  localparam logic [15:0] compare_unit1_secondary       = 16'h0180;
  localparam logic [15:0] compare_unit1_primary         = 16'h0182;
  localparam logic [15:0] compare_unit2_secondary       = 16'h0186;
  localparam logic [15:0] compare_unit2_primary         = 16'h0188;
  localparam logic [15:0] uart_a_transmit_holding       = 16'h0224;
  localparam logic [15:0] uart_a_receive_holding        = 16'h0226;
  localparam logic [15:0] uart_b_transmit_holding       = 16'h0234;
  localparam logic [15:0] uart_b_receive_holding        = 16'h0236;
  localparam logic [15:0] serial_port_a_buffer          = 16'h0248;
  localparam logic [15:0] serial_port_b_buffer          = 16'h0268;
  localparam logic [15:0] codec_receive_buffer_first    = 16'h0290;
  localparam logic [15:0] codec_transmit_buffer_first   = 16'h0298;
  localparam logic [15:0] converter_result_buffer_first = 16'h0300;
  localparam logic [15:0] audio_dac_right_data          = 16'h03f6;
  localparam logic [15:0] audio_dac_left_data           = 16'h03f8;
  localparam logic [15:0] can_receive_data              = 16'h0440;
  localparam logic [15:0] can_transmit_data             = 16'h0442;
  localparam logic [15:0] parallel_port_data            = 16'h0608;
  localparam logic [15:0] NO_ADDR                       = 16'h0000;

  // Reset values and buffer shape
  localparam int unsigned BUF_DEPTH    = 2;
  localparam logic [1:0]  BUF_CNT_RST  = 2'h0;
  localparam logic        PTR_RST      = 1'h0;
endpackage

// file: tb/dma_far_side_model.sv
// Behavioural peripheral register bus and DMA RAM facing the channel.
// Assumes the channel's valid/ready scheme with zero-wait read data on ref_clk.
`timescale 1ns/1ps
module dma_far_side_model (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        per_stall,
  input  wire logic        ram_stall,
  input  wire logic        per_valid,
  input  wire logic        per_write,
  input  wire logic [15:0] per_addr,
  input  wire logic [15:0] per_wdata,
  output logic [15:0]      per_rdata,
  output logic             per_ready,
  input  wire logic        ram_valid,
  input  wire logic        ram_write,
  input  wire logic [10:0] ram_addr,
  input  wire logic [15:0] ram_wdata,
  output logic [15:0]      ram_rdata,
  output logic             ram_ready
);
  logic [15:0] mem      [0:2047];
  logic [15:0] per_log  [0:15];
  logic [15:0] addr_log [0:15];
  logic [15:0] rd_addr;
  logic [15:0] rd_word;
  int unsigned per_n;
  int unsigned rd_n;
  // Ready follows valid unless a stall is held; read data is zero-wait
  assign rd_word   = 16'ha000 + rd_n[15:0];
  assign per_ready = per_valid & ~per_stall;
  assign ram_ready = ram_valid & ~ram_stall;
  assign per_rdata = per_valid ? rd_word : ~rd_word;  // Unselected: never the held word
  assign ram_rdata = ram_valid ? mem[ram_addr] : ~mem[ram_addr];  // Buffers in DMA RAM
  // Peripheral side: count reads, log writes with their address
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      per_n <= 0;
      rd_n  <= 0;
    end else if (per_valid && per_ready && per_write) begin
      per_log[per_n[3:0]]  <= per_wdata;
      addr_log[per_n[3:0]] <= per_addr;
      per_n                <= per_n + 1;
    end else if (per_valid && per_ready) begin
      rd_addr <= per_addr;
      rd_n    <= rd_n + 1;
    end
  end
  // RAM store on handshake; the bench preloads source words directly
  always @(posedge ref_clk) begin
    if (ram_valid && ram_ready && ram_write) begin
      mem[ram_addr] <= ram_wdata;
    end
  end
endmodule // dma_far_side_model

// file: tb/dma_peripheral_request_map_tb_top.sv
// Self-checking bench for the request-mapped DMA channel.
// Assumes the far-side model for peripheral bus and DMA RAM, one 125 MHz clock.
`timescale 1ns/1ps
module dma_peripheral_request_map_tb_top;
  logic          ref_clk = 1'b0;
  logic          reset_n = 1'b0;
  logic          clk_en = 1'b1;
  logic          channel_enable = 1'b0;
  logic          to_peripheral = 1'b0;
  logic [6:0]    request_source_code = 7'h00;
  logic [15:0]   channel_peripheral_address = 16'h0000;
  logic [10:0]   ram_start = 11'h000;
  logic [9:0]    block_last = 10'h000;
  logic [127:0]  request_lines = '0;
  logic          per_stall = 1'b0;
  logic          ram_stall = 1'b0;
  logic          per_valid, per_write, per_ready, ram_valid, ram_write, ram_ready;
  logic          address_mismatch, busy, block_done;
  logic [15:0]   per_addr, per_wdata, per_rdata, ram_wdata, ram_rdata;
  logic [10:0]   ram_addr;
  int            err_total = 0;
  int            checks = 0;

  dma_peripheral_request_map dut (
    .ref_clk                    (ref_clk),
    .reset_n                    (reset_n),
    .clk_en                     (clk_en),
    .channel_enable             (channel_enable),
    .to_peripheral              (to_peripheral),
    .request_source_code        (request_source_code),
    .channel_peripheral_address (channel_peripheral_address),
    .ram_start                  (ram_start),
    .block_last                 (block_last),
    .request_lines              (request_lines),
    .per_valid                  (per_valid),
    .per_write                  (per_write),
    .per_addr                   (per_addr),
    .per_wdata                  (per_wdata),
    .per_rdata                  (per_rdata),
    .per_ready                  (per_ready),
    .ram_valid                  (ram_valid),
    .ram_write                  (ram_write),
    .ram_addr                   (ram_addr),
    .ram_wdata                  (ram_wdata),
    .ram_rdata                  (ram_rdata),
    .ram_ready                  (ram_ready),
    .address_mismatch           (address_mismatch),
    .busy                       (busy),
    .block_done                 (block_done)
  );
  dma_far_side_model far (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .per_stall (per_stall),
    .ram_stall (ram_stall),
    .per_valid (per_valid),
    .per_write (per_write),
    .per_addr  (per_addr),
    .per_wdata (per_wdata),
    .per_rdata (per_rdata),
    .per_ready (per_ready),
    .ram_valid (ram_valid),
    .ram_write (ram_write),
    .ram_addr  (ram_addr),
    .ram_wdata (ram_wdata),
    .ram_rdata (ram_rdata),
    .ram_ready (ram_ready)
  );

  // Clock and reset
  always #4 ref_clk = ~ref_clk;
  initial begin
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask

  task automatic setup(input logic [6:0] c, input logic [15:0] a, input logic d);
    @(posedge ref_clk);
    channel_enable             <= 1'b1;
    request_source_code        <= c;
    channel_peripheral_address <= a;
    to_peripheral              <= d;
    @(negedge ref_clk);
  endtask

  task automatic map_one(input logic [6:0] c, input logic [15:0] a, input logic d, input logic e);
    setup(c, a, d);
    check(address_mismatch, e, "map verdict");
  endtask

  // Request held n cycles counts n triggers
  task automatic trig(input logic [6:0] c, input int n);
    @(posedge ref_clk);
    request_lines <= 128'h1 << c;
    repeat (n) @(posedge ref_clk);
    request_lines <= '0;
  endtask

  task automatic wait_done();
    int i;
    i = 0;
    while (block_done !== 1'b1 && i < 200) begin
      @(negedge ref_clk);
      i++;
    end
    check(16'(i < 200), 16'h0001, "block not done");
  endtask

  task automatic test_reset();
    @(negedge ref_clk);
    check({per_valid, ram_valid, busy, block_done}, 16'h0000, "reset outputs");
    $display("test reset done");
  endtask

  task automatic test_map();
    map_one(7'h00, 16'h1234, 1'b0, 1'b0);
    map_one(7'h00, 16'h0140, 1'b1, 1'b0);
    map_one(7'h07, 16'h0000, 1'b1, 1'b0);
    map_one(7'h08, 16'h0000, 1'b0, 1'b0);
    map_one(7'h01, 16'h0140, 1'b0, 1'b0);
    map_one(7'h01, 16'h0140, 1'b1, 1'b1);
    map_one(7'h02, 16'h0182, 1'b1, 1'b0);
    map_one(7'h02, 16'h0180, 1'b1, 1'b0);
    map_one(7'h02, 16'h0182, 1'b0, 1'b1);
    map_one(7'h05, 16'h0144, 1'b0, 1'b0);
    map_one(7'h06, 16'h0188, 1'b1, 1'b0);
    map_one(7'h06, 16'h0186, 1'b1, 1'b0);
    map_one(7'h0a, 16'h0248, 1'b1, 1'b0);
    map_one(7'h0b, 16'h0226, 1'b0, 1'b0);
    map_one(7'h0c, 16'h0224, 1'b1, 1'b0);
    map_one(7'h0d, 16'h0300, 1'b0, 1'b0);
    map_one(7'h1e, 16'h0236, 1'b0, 1'b0);
    map_one(7'h1f, 16'h0234, 1'b1, 1'b0);
    map_one(7'h21, 16'h0268, 1'b0, 1'b0);
    map_one(7'h22, 16'h0440, 1'b0, 1'b0);
    map_one(7'h46, 16'h0442, 1'b1, 1'b0);
    map_one(7'h2d, 16'h0608, 1'b1, 1'b0);
    map_one(7'h3c, 16'h0290, 1'b0, 1'b0);
    map_one(7'h3c, 16'h0298, 1'b1, 1'b0);
    map_one(7'h3c, 16'h0290, 1'b1, 1'b1);
    map_one(7'h4e, 16'h03f6, 1'b1, 1'b0);
    map_one(7'h4f, 16'h03f8, 1'b1, 1'b0);
    map_one(7'h4e, 16'h03f6, 1'b0, 1'b1);
    $display("test map done");
  endtask

  // Three back-to-back capture events land in RAM with the RAM stalling once
  task automatic test_read();
    @(posedge ref_clk);
    ram_start  <= 11'h010;
    block_last <= 10'h002;
    ram_stall  <= 1'b1;
    setup(7'h01, 16'h0140, 1'b0);
    trig(7'h01, 3);
    repeat (3) @(posedge ref_clk);
    ram_stall <= 1'b0;
    wait_done();
    for (int i = 0; i < 3; i++) begin
      check(far.mem[16 + i], 16'ha000 + 16'(i), "read word");
    end
    check(far.rd_addr, 16'h0140, "read address");
    $display("test read done");
  endtask

  // Peripheral stalls while four words back up; all reach it in order
  task automatic test_write();
    @(posedge ref_clk);
    channel_enable <= 1'b0;
    for (int i = 0; i < 4; i++) far.mem[32 + i] = 16'h5a00 + 16'(i);
    ram_start  <= 11'h020;
    block_last <= 10'h003;
    per_stall  <= 1'b1;
    setup(7'h0a, 16'h0248, 1'b1);
    trig(7'h0a, 4);
    repeat (6) @(negedge ref_clk);
    check(busy, 1'b1, "busy while stalled");
    check(16'(far.per_n), 16'h0000, "write during stall");
    // Freeze the channel while the peripheral frees up: no request may be offered
    @(posedge ref_clk);
    clk_en    <= 1'b0;
    per_stall <= 1'b0;
    repeat (3) @(negedge ref_clk);
    check(16'(far.per_n), 16'h0000, "write while frozen");
    @(posedge ref_clk);
    clk_en <= 1'b1;
    wait_done();
    check(16'(far.per_n), 16'h0004, "write count");
    for (int i = 0; i < 4; i++) begin
      check(far.per_log[i], 16'h5a00 + 16'(i), "write word");
      check(far.addr_log[i], 16'h0248, "write address");
    end
    $display("test write done");
  endtask

  // Wrong address and an unlisted code move nothing
  task automatic test_refuse();
    setup(7'h01, 16'h0144, 1'b0);
    trig(7'h01, 2);
    repeat (5) @(negedge ref_clk);
    check({address_mismatch, busy}, 16'h0002, "mismatch state");
    setup(7'h03, 16'h0000, 1'b0);
    trig(7'h03, 2);
    repeat (5) @(negedge ref_clk);
    check(16'(far.rd_n), 16'h0003, "refused read");
    $display("test refuse done");
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Watchdog: tests take well under a thousand cycles
  initial begin
    #40000;
    err_total++;
    summarize();
  end

  // Main sequence
  initial begin
    repeat (2) @(posedge ref_clk);
    test_reset();
    wait (reset_n === 1'b1);
    test_map();
    test_read();
    test_write();
    test_refuse();
    summarize();
  end
endmodule // dma_peripheral_request_map_tb_top

// file: verilog/dma_peripheral_request_map.sv
// Single DMA channel: peripheral request select, address map check, word mover.
// Assumes request lines, peripheral bus and DMA RAM port all run on ref_clk.
`timescale 1ns/1ps

module dma_peripheral_request_map #(
  parameter int unsigned DATA_W = 16,
  parameter int unsigned RAM_AW = 11,
  parameter int unsigned CNT_W  = 10
) (
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  input  wire logic              clk_en,
  input  wire logic              channel_enable,
  input  wire logic              to_peripheral,
  input  wire logic [6:0]        request_source_code,
  input  wire logic [15:0]       channel_peripheral_address,
  input  wire logic [RAM_AW-1:0] ram_start,
  input  wire logic [CNT_W-1:0]  block_last,
  input  wire logic [127:0]      request_lines,
  output logic                   per_valid,
  output logic                   per_write,
  output logic [15:0]            per_addr,
  output logic [DATA_W-1:0]      per_wdata,
  input  wire logic [DATA_W-1:0] per_rdata,
  input  wire logic              per_ready,
  output logic                   ram_valid,
  output logic                   ram_write,
  output logic [RAM_AW-1:0]      ram_addr,
  output logic [DATA_W-1:0]      ram_wdata,
  input  wire logic [DATA_W-1:0] ram_rdata,
  input  wire logic              ram_ready,
  output logic                   address_mismatch,
  output logic                   busy,
  output logic                   block_done
);
  if (DATA_W < 1 || RAM_AW < 1 || CNT_W < 1 || CNT_W > 16) begin : g_param_check
    $error("dma_peripheral_request_map: unsupported parameter values");
  end

  // Map entry for the selected code
  logic        code_known;
  logic        rd_def;
  logic        wr_def;
  logic        wr_alt_def;
  logic [15:0] rd_addr;
  logic [15:0] wr_addr;
  logic [15:0] wr_alt_addr;

  // Code decode: trigger plus legal read and write addresses
  always_comb begin
    code_known  = 1'b1;
    rd_def      = 1'b0;
    wr_def      = 1'b0;
    wr_alt_def  = 1'b0;
    rd_addr     = dma_map_pkg::NO_ADDR;
    wr_addr     = dma_map_pkg::NO_ADDR;
    wr_alt_addr = dma_map_pkg::NO_ADDR;
    case (request_source_code)
      dma_map_pkg::SRC_EXT_INT_ZERO, dma_map_pkg::SRC_TIMER_2,
      dma_map_pkg::SRC_TIMER_3: begin
        code_known = 1'b1; // Trigger only, no address
      end
      dma_map_pkg::SRC_CAPTURE_1: begin
        rd_def  = 1'b1;
        rd_addr = dma_map_pkg::capture_unit1_buffer;
      end
      dma_map_pkg::SRC_COMPARE_1: begin
        wr_def      = 1'b1;
        wr_alt_def  = 1'b1;
        wr_addr     = dma_map_pkg::compare_unit1_primary;
        wr_alt_addr = dma_map_pkg::compare_unit1_secondary;
      end
      dma_map_pkg::SRC_CAPTURE_2: begin
        rd_def  = 1'b1;
        rd_addr = dma_map_pkg::capture_unit2_buffer;
      end
      dma_map_pkg::SRC_COMPARE_2: begin
        wr_def      = 1'b1;
        wr_alt_def  = 1'b1;
        wr_addr     = dma_map_pkg::compare_unit2_primary;
        wr_alt_addr = dma_map_pkg::compare_unit2_secondary;
      end
      dma_map_pkg::SRC_SERIAL_A: begin
        rd_def  = 1'b1;
        wr_def  = 1'b1;
        rd_addr = dma_map_pkg::serial_port_a_buffer;
        wr_addr = dma_map_pkg::serial_port_a_buffer;
      end
      dma_map_pkg::SRC_UART_A_RX: begin
        rd_def  = 1'b1;
        rd_addr = dma_map_pkg::uart_a_receive_holding;
      end
      dma_map_pkg::SRC_UART_A_TX: begin
        wr_def  = 1'b1;
        wr_addr = dma_map_pkg::uart_a_transmit_holding;
      end
      dma_map_pkg::SRC_CONVERTER: begin
        rd_def  = 1'b1;
        rd_addr = dma_map_pkg::converter_result_buffer_first;
      end
      dma_map_pkg::SRC_UART_B_RX: begin
        rd_def  = 1'b1;
        rd_addr = dma_map_pkg::uart_b_receive_holding;
      end
      dma_map_pkg::SRC_UART_B_TX: begin
        wr_def  = 1'b1;
        wr_addr = dma_map_pkg::uart_b_transmit_holding;
      end
      dma_map_pkg::SRC_SERIAL_B: begin
        rd_def  = 1'b1;
        wr_def  = 1'b1;
        rd_addr = dma_map_pkg::serial_port_b_buffer;
        wr_addr = dma_map_pkg::serial_port_b_buffer;
      end
      dma_map_pkg::SRC_CAN_RX: begin
        rd_def  = 1'b1;
        rd_addr = dma_map_pkg::can_receive_data;
      end
      dma_map_pkg::SRC_CAN_TX: begin
        wr_def  = 1'b1;
        wr_addr = dma_map_pkg::can_transmit_data;
      end
      dma_map_pkg::SRC_PARALLEL_PORT: begin
        rd_def  = 1'b1;
        wr_def  = 1'b1;
        rd_addr = dma_map_pkg::parallel_port_data;
        wr_addr = dma_map_pkg::parallel_port_data;
      end
      dma_map_pkg::SRC_CODEC: begin
        rd_def  = 1'b1;
        wr_def  = 1'b1;
        rd_addr = dma_map_pkg::codec_receive_buffer_first;
        wr_addr = dma_map_pkg::codec_transmit_buffer_first;
      end
      dma_map_pkg::SRC_DAC_RIGHT: begin
        wr_def  = 1'b1;
        wr_addr = dma_map_pkg::audio_dac_right_data;
      end
      dma_map_pkg::SRC_DAC_LEFT: begin
        wr_def  = 1'b1;
        wr_addr = dma_map_pkg::audio_dac_left_data;
      end
      default: code_known = 1'b0;
    endcase
  end

  // Address check against the map; trigger-only codes accept any address,
  // a direction that has no map entry for a mapped code is refused
  wire wr_match   = (channel_peripheral_address == wr_addr) ||
                    (wr_alt_def && channel_peripheral_address == wr_alt_addr);
  wire rd_match   = (channel_peripheral_address == rd_addr);
  wire trig_only  = !rd_def && !wr_def;
  wire dir_ok     = to_peripheral ? (wr_def && wr_match) : (rd_def && rd_match);
  wire addr_ok    = trig_only || dir_ok;
  wire run        = channel_enable && code_known && addr_ok;
  wire trigger    = run && request_lines[request_source_code];

  // Two-entry buffer state
  logic [DATA_W-1:0] buf_mem [dma_map_pkg::BUF_DEPTH];
  logic              buf_wptr;
  logic              buf_rptr;
  logic [1:0]        buf_cnt;
  logic [15:0]       pending;
  logic [CNT_W-1:0]  issue_idx;
  logic [CNT_W-1:0]  store_idx;

  // Source fetch and sink store handshakes
  wire buf_full    = (buf_cnt == 2'd2);
  wire buf_empty   = (buf_cnt == dma_map_pkg::BUF_CNT_RST);
  wire src_valid   = run && clk_en && (pending != 16'h0000) && !buf_full; // No request frozen
  wire src_ready   = to_peripheral ? ram_ready : per_ready;
  wire src_hs      = src_valid && src_ready; // One word per trigger
  wire snk_valid   = run && clk_en && !buf_empty;
  wire snk_ready   = to_peripheral ? per_ready : ram_ready;
  wire snk_hs      = snk_valid && snk_ready;
  wire [DATA_W-1:0] src_data = to_peripheral ? ram_rdata : per_rdata;
  wire [DATA_W-1:0] head     = buf_mem[buf_rptr];
  wire pend_sat    = (pending == 16'hffff);
  wire issue_wrap  = (issue_idx == block_last);
  wire store_wrap  = (store_idx == block_last);

  // Bus steering: peripheral and RAM buses are the channel's own
  assign per_valid = to_peripheral ? snk_valid : src_valid;
  assign per_write = to_peripheral;
  assign per_addr  = channel_peripheral_address;
  assign per_wdata = head;
  assign ram_valid = to_peripheral ? src_valid : snk_valid;
  assign ram_write = !to_peripheral;
  assign ram_addr  = ram_start + (to_peripheral ? RAM_AW'(issue_idx) : RAM_AW'(store_idx));
  assign ram_wdata = head;
  assign address_mismatch = channel_enable && !(code_known && addr_ok);
  assign busy      = run && ((pending != 16'h0000) || !buf_empty);

  // Pending triggers: an arriving request is never lost to a completing word
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pending <= 16'h0000;
    end else if (clk_en) begin
      if (!run) begin
        pending <= 16'h0000;
      end else if (trigger && !src_hs && !pend_sat) begin
        pending <= pending + 16'h0001;
      end else if (!trigger && src_hs) begin
        pending <= pending - 16'h0001;
      end
    end
  end

  // Buffer write side
  always_ff @(posedge ref_clk) begin
    if (clk_en && src_hs) begin
      buf_mem[buf_wptr] <= src_data;
    end
  end

  // Buffer pointers and occupancy
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      buf_wptr <= dma_map_pkg::PTR_RST;
      buf_rptr <= dma_map_pkg::PTR_RST;
      buf_cnt  <= dma_map_pkg::BUF_CNT_RST;
    end else if (clk_en) begin
      if (!run) begin
        buf_wptr <= dma_map_pkg::PTR_RST;
        buf_rptr <= dma_map_pkg::PTR_RST;
        buf_cnt  <= dma_map_pkg::BUF_CNT_RST;
      end else begin
        buf_wptr <= buf_wptr ^ src_hs;
        buf_rptr <= buf_rptr ^ snk_hs;
        buf_cnt  <= buf_cnt + {1'b0, src_hs} - {1'b0, snk_hs};
      end
    end
  end

  // Block position counters and completion pulse
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      issue_idx  <= '0;
      store_idx  <= '0;
      block_done <= 1'b0;
    end else if (clk_en) begin
      block_done <= run && snk_hs && store_wrap;
      if (!run) begin
        issue_idx <= '0;
        store_idx <= '0;
      end else begin
        if (src_hs) begin
          issue_idx <= issue_wrap ? '0 : issue_idx + 1'b1;
        end
        if (snk_hs) begin
          store_idx <= store_wrap ? '0 : store_idx + 1'b1;
        end
      end
    end
  end

  // Checks
  map_capture1_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (request_source_code == 7'h01) |-> (rd_def && rd_addr == 16'h0140 && !wr_def))
    else $error("capture 1 map wrong");
  map_compare1_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (request_source_code == 7'h02) |-> (wr_addr == 16'h0182 && wr_alt_addr == 16'h0180 && !rd_def))
    else $error("compare 1 map wrong");
  map_ext_int_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (request_source_code == 7'h00 && channel_enable) |-> (!rd_def && !wr_def && !address_mismatch))
    else $error("external interrupt map wrong");
  map_codec_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (request_source_code == 7'h3c) |-> (rd_addr == 16'h0290 && wr_addr == 16'h0298))
    else $error("codec map wrong");
  word_per_trig_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (clk_en && src_hs && !trigger) |=> (pending == $past(pending) - 16'h0001))
    else $error("word moved without pending trigger count drop");
  trigger_kept_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (clk_en && run && trigger && !src_hs && !pend_sat) |=> (pending == $past(pending) + 16'h0001))
    else $error("trigger lost");
  buf_no_over_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    src_hs |-> (buf_cnt < 2'd2))
    else $error("buffer overflow");
  stall_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (per_valid && per_write && !per_ready && clk_en && run) ##1 (clk_en && run)
      |-> (per_valid && $stable(per_wdata)))
    else $error("stalled write data changed");
  block_done_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    block_done |-> ($past(snk_hs) && $past(store_wrap) && store_idx == '0))
    else $error("block done without last store");
  own_bus_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (per_valid || ram_valid) |-> (run && !(per_valid && ram_valid && per_write == ram_write)))
    else $error("bus driven while channel idle");
  read_path_c: cover property (@(posedge ref_clk) disable iff (!reset_n)
    (!to_peripheral && trigger) ##[1:20] (ram_valid && ram_ready));
  write_path_c: cover property (@(posedge ref_clk) disable iff (!reset_n)
    (to_peripheral && trigger) ##[1:20] (per_valid && per_ready));
  full_stall_c: cover property (@(posedge ref_clk) disable iff (!reset_n)
    buf_full && !snk_ready);
  block_end_c: cover property (@(posedge ref_clk) disable iff (!reset_n) block_done);
endmodule // dma_peripheral_request_map
